// ==== ccv_pkg.sv ====
/*
 * Constants, field layout and state type for the capture/compare value
 * registers of the five-module programmable counter array.
 * Assumes an 8-bit special function register bus and one system clock.
 */
package ccv_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int MOD_COUNT = 5;
	localparam int IDX_W     = 3;
	localparam int BYTE_W    = 8;
	localparam int VALUE_W   = 16;

	// ----------------------------------------
	// Register addresses, indexed by module
	// ----------------------------------------
	localparam logic [MOD_COUNT-1:0][7:0] ADDR_LOW  = {8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb};
	localparam logic [MOD_COUNT-1:0][7:0] ADDR_HIGH = {8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc};

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int          LOW_LSB     = 0;
	localparam int          HIGH_LSB    = 8;
	localparam int          CMP_EN_BIT  = 6;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [7:0]  IDLE_READ   = 8'h00;
	localparam int          READ_CYCLES = 1;

	typedef struct packed {
		logic [MOD_COUNT-1:0][VALUE_W-1:0] value;
		logic [MOD_COUNT-1:0]              cmpEn;
		logic [BYTE_W-1:0]                 rdData;
	} ccv_state_t;

	typedef struct packed {
		logic match;
	} ccv_cmp_state_t;

endpackage : ccv_pkg

// ==== ccv_sfr_if.sv ====
/*
 * Decoded register-bus view shared between the value register core and
 * its address decoder. Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface ccv_sfr_if;
	import ccv_pkg::*;
	logic [7:0]       addr;
	logic             write;
	logic             read;
	logic             hit;
	logic             isHigh;
	logic [IDX_W-1:0] idx;

	modport decoder (input addr, input write, input read, output hit, output isHigh, output idx);
	modport core (output addr, output write, output read, input hit, input isHigh, input idx);
endinterface : ccv_sfr_if

// ==== ccv_sfr_decode.sv ====
/*
 * Address decoder: maps a register address onto module index and byte.
 * Assumes the address is stable in the cycle of its strobe.
 */
`timescale 1ns/100ps
module ccv_sfr_decode
	import ccv_pkg::*;
(
	ccv_sfr_if.decoder bus
);

	// ----------------------------------------
	// Lookup
	// ----------------------------------------
	// Returns {hit, isHigh, idx}; misses decode to module 0, low byte
	function automatic logic [IDX_W+1:0] lookup(input logic [7:0] a);
		logic [IDX_W+1:0] r;
		r = '0;
		for (int i = 0; i < MOD_COUNT; i++) begin
			if (a == ADDR_LOW[i]) begin
				r = {1'b1, 1'b0, IDX_W'(i)};
			end else if (a == ADDR_HIGH[i]) begin
				r = {1'b1, 1'b1, IDX_W'(i)};
			end
		end
		return r;
	endfunction : lookup

	always_comb begin
		{bus.hit, bus.isHigh, bus.idx} = lookup(bus.addr);
	end

endmodule : ccv_sfr_decode

// ==== ccv_comparator.sv ====
/*
 * One module's comparator: flags a match of counter and stored value.
 * Assumes the counter comes from logic on the same clock.
 */
`timescale 1ns/100ps
module ccv_comparator
	import ccv_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               enable,
	input  wire logic [VALUE_W-1:0] counter,
	input  wire logic [VALUE_W-1:0] value,
	output logic                    match
);

	ccv_cmp_state_t s;
	ccv_cmp_state_t next_s;

	// ----------------------------------------
	// Compare
	// ----------------------------------------
	always_comb begin
		next_s       = s;
		next_s.match = enable && (counter == value);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign match = s.match;

endmodule : ccv_comparator

// ==== ccv_value_regs.sv ====
/*
 * Capture/compare value registers of the five counter-array modules,
 * their compare enable bits and comparators.
 * Assumes the processor register bus gives one address, a write strobe
 * and a read strobe per cycle, and that the mode registers live outside
 * this block and report their writes on modeWrite/modeWrData.
 */
`timescale 1ns/100ps
module ccv_value_regs
	import ccv_pkg::*;
(
	input  wire logic                              clock,
	input  wire logic                              rst,
	input  wire logic [7:0]                        sfrAddr,
	input  wire logic                              sfrWrite,
	input  wire logic                              sfrRead,
	input  wire logic [BYTE_W-1:0]                 sfrWrData,
	output logic      [BYTE_W-1:0]                 sfrRdData,
	input  wire logic [MOD_COUNT-1:0]              modeWrite,
	input  wire logic [BYTE_W-1:0]                 modeWrData,
	input  wire logic [VALUE_W-1:0]                counter,
	output logic      [MOD_COUNT-1:0]              compareEnable,
	output logic      [MOD_COUNT-1:0][VALUE_W-1:0] moduleValue,
	output logic      [MOD_COUNT-1:0]              compareMatch
);

	ccv_state_t s;
	ccv_state_t next_s;
	ccv_sfr_if  bus ();

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign bus.addr  = sfrAddr;
	assign bus.write = sfrWrite;
	assign bus.read  = sfrRead;

	ccv_sfr_decode u_decode (
		.bus (bus)
	);

	logic lowWr;
	logic highWr;
	logic anyRd;

	assign lowWr  = bus.write && bus.hit && !bus.isHigh;
	assign highWr = bus.write && bus.hit && bus.isHigh;
	assign anyRd  = bus.read && bus.hit;

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	// Mode register writes come first so a value write in the same cycle
	// decides the enable; on one shared bus they never truly coincide.
	always_comb begin
		next_s        = s;
		next_s.rdData = IDLE_READ;
		for (int i = 0; i < MOD_COUNT; i++) begin
			if (modeWrite[i]) begin
				next_s.cmpEn[i] = modeWrData[CMP_EN_BIT];
			end
		end
		if (lowWr) begin
			next_s.value[bus.idx][LOW_LSB +: BYTE_W] = sfrWrData;
			next_s.cmpEn[bus.idx]                    = 1'b0;
		end else if (highWr) begin
			next_s.value[bus.idx][HIGH_LSB +: BYTE_W] = sfrWrData;
			next_s.cmpEn[bus.idx]                     = 1'b1;
		end
		// Unmapped reads return zero rather than holding stale data
		if (anyRd) begin
			if (bus.isHigh) begin
				next_s.rdData = s.value[bus.idx][HIGH_LSB +: BYTE_W];
			end else begin
				next_s.rdData = s.value[bus.idx][LOW_LSB +: BYTE_W];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sfrRdData     = s.rdData;
	assign compareEnable = s.cmpEn;
	assign moduleValue   = s.value;

	// ----------------------------------------
	// Comparators
	// ----------------------------------------
	// Low byte first suspends the compare until the high byte lands or a mode
	// write sets CMP_EN_BIT; only such a mode write lets a half-updated value match.
	generate
		for (genvar g = 0; g < MOD_COUNT; g++) begin : g_cmp
			ccv_comparator u_cmp (
				.clock   (clock),
				.rst     (rst),
				.enable  (s.cmpEn[g]),
				.counter (counter),
				.value   (s.value[g]),
				.match   (compareMatch[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_low_write;
		lowWr;
	endsequence

	sequence s_high_write;
		highWr;
	endsequence

	property p_low_store;
		@(posedge clock) disable iff (rst)
		s_low_write |=> (s.value[$past(bus.idx)][LOW_LSB +: BYTE_W] == $past(sfrWrData));
	endproperty
	a_low_store: assert property (p_low_store) else $error("low byte not stored");

	property p_high_store;
		@(posedge clock) disable iff (rst)
		s_high_write |=> (s.value[$past(bus.idx)][HIGH_LSB +: BYTE_W] == $past(sfrWrData));
	endproperty
	a_high_store: assert property (p_high_store) else $error("high byte not stored");

	property p_low_keeps_high;
		@(posedge clock) disable iff (rst)
		s_low_write
			|=> (s.value[$past(bus.idx)][HIGH_LSB +: BYTE_W] == $past(s.value[bus.idx][HIGH_LSB +: BYTE_W]));
	endproperty
	a_low_keeps_high: assert property (p_low_keeps_high) else $error("low write hit high byte");

	property p_low_clears_en;
		@(posedge clock) disable iff (rst)
		s_low_write |=> !compareEnable[$past(bus.idx)];
	endproperty
	a_low_clears_en: assert property (p_low_clears_en) else $error("low write left enable set");

	property p_high_sets_en;
		@(posedge clock) disable iff (rst)
		s_high_write |=> compareEnable[$past(bus.idx)];
	endproperty
	a_high_sets_en: assert property (p_high_sets_en) else $error("high write left enable clear");

	property p_m0_low_addr;
		@(posedge clock) disable iff (rst)
		(sfrWrite && sfrAddr == 8'hfb) |=> (moduleValue[0][7:0] == $past(sfrWrData)) && !compareEnable[0];
	endproperty
	a_m0_low_addr: assert property (p_m0_low_addr) else $error("module 0 low byte misdecoded");

	property p_m0_high_addr;
		@(posedge clock) disable iff (rst)
		(sfrWrite && sfrAddr == 8'hfc) |=> (moduleValue[0][15:8] == $past(sfrWrData)) && compareEnable[0];
	endproperty
	a_m0_high_addr: assert property (p_m0_high_addr) else $error("module 0 high byte misdecoded");

	property p_read_back;
		@(posedge clock) disable iff (rst)
		(anyRd && !bus.isHigh) |=> (sfrRdData == $past(s.value[bus.idx][7:0]));
	endproperty
	a_read_back: assert property (p_read_back) else $error("low byte read wrong");

	property p_unmapped_read;
		@(posedge clock) disable iff (rst)
		(sfrRead && !bus.hit) |=> (sfrRdData == 8'h00);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_high_read_back;
		@(posedge clock) disable iff (rst)
		(anyRd && bus.isHigh)
			|=> (sfrRdData == $past(s.value[bus.idx][15:8]));
	endproperty
	a_high_read_back: assert property (p_high_read_back) else $error("high byte read wrong");

	property p_idle_read;
		@(posedge clock) disable iff (rst)
		!sfrRead
			|=> (sfrRdData == IDLE_READ);
	endproperty
	a_idle_read: assert property (p_idle_read) else $error("read data not idle");

	// Stray addresses must leave values and enables alone
	property p_unmapped_write;
		@(posedge clock) disable iff (rst)
		(sfrWrite && !bus.hit)
			|=> $stable(moduleValue);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed value");

	property p_unmapped_keeps_en;
		@(posedge clock) disable iff (rst)
		(sfrWrite && !bus.hit && (modeWrite == '0))
			|=> $stable(compareEnable);
	endproperty
	a_unmapped_keeps_en: assert property (p_unmapped_keeps_en) else $error("unmapped write changed enable");

	property p_reset_match;
		@(posedge clock)
		rst
			|=> (compareMatch == '0);
	endproperty
	a_reset_match: assert property (p_reset_match) else $error("match survived reset");

	property p_reset_zero;
		@(posedge clock)
		rst |=> (moduleValue == '0) && (compareEnable == '0) && (sfrRdData == 8'h00);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset value not zero");

	generate
		for (genvar k = 0; k < MOD_COUNT; k++) begin : g_chk
			property p_match;
				@(posedge clock) disable iff (rst)
				(s.cmpEn[k] && counter == s.value[k]) |=> compareMatch[k];
			endproperty
			a_match: assert property (p_match) else $error("enabled compare missed match");

			property p_no_match_off;
				@(posedge clock) disable iff (rst)
				!s.cmpEn[k] |=> !compareMatch[k];
			endproperty
			a_no_match_off: assert property (p_no_match_off) else $error("match while disabled");

			property p_split_update;
				@(posedge clock) disable iff (rst)
				(lowWr && bus.idx == k) ##1 (!modeWrite[k] && !(highWr && bus.idx == k)) [*2]
					|=> !compareMatch[k];
			endproperty
			a_split_update: assert property (p_split_update) else $error("match during split update");

			// Each module answers at its own pair of addresses
			property p_low_addr;
				@(posedge clock) disable iff (rst)
				(sfrWrite && (sfrAddr == ADDR_LOW[k]))
					|=> (moduleValue[k][7:0] == $past(sfrWrData)) && !compareEnable[k];
			endproperty
			a_low_addr: assert property (p_low_addr) else $error("low byte address misdecoded");

			property p_high_addr;
				@(posedge clock) disable iff (rst)
				(sfrWrite && (sfrAddr == ADDR_HIGH[k]))
					|=> (moduleValue[k][15:8] == $past(sfrWrData)) && compareEnable[k];
			endproperty
			a_high_addr: assert property (p_high_addr) else $error("high byte address misdecoded");

			property p_high_keeps_low;
				@(posedge clock) disable iff (rst)
				(highWr && (bus.idx == k))
					|=> $stable(s.value[k][7:0]);
			endproperty
			a_high_keeps_low: assert property (p_high_keeps_low) else $error("high write hit low byte");

			property p_value_hold;
				@(posedge clock) disable iff (rst)
				!((lowWr || highWr) && (bus.idx == k))
					|=> $stable(moduleValue[k]);
			endproperty
			a_value_hold: assert property (p_value_hold) else $error("value changed without write");

			property p_mode_loads_en;
				@(posedge clock) disable iff (rst)
				(modeWrite[k] && !((lowWr || highWr) && (bus.idx == k)))
					|=> (compareEnable[k] == $past(modeWrData[CMP_EN_BIT]));
			endproperty
			a_mode_loads_en: assert property (p_mode_loads_en) else $error("mode write not mirrored");

			property p_en_hold;
				@(posedge clock) disable iff (rst)
				(!modeWrite[k] && !((lowWr || highWr) && (bus.idx == k)))
					|=> $stable(compareEnable[k]);
			endproperty
			a_en_hold: assert property (p_en_hold) else $error("enable changed without write");

			sequence s_pair_write;
				(lowWr && (bus.idx == k)) ##1 (highWr && (bus.idx == k));
			endsequence

			property p_pair_update;
				@(posedge clock) disable iff (rst)
				s_pair_write
					|=> compareEnable[k] && (moduleValue[k] == {$past(sfrWrData), $past(sfrWrData, 2)});
			endproperty
			a_pair_update: assert property (p_pair_update) else $error("paired write not assembled");

			// Comparator lags the enable by one register stage
			property p_low_stops_match;
				@(posedge clock) disable iff (rst)
				(lowWr && (bus.idx == k))
					|=> ##1 !compareMatch[k];
			endproperty
			a_low_stops_match: assert property (p_low_stops_match) else $error("match after low write");

			property p_match_cause;
				@(posedge clock) disable iff (rst)
				compareMatch[k]
					|-> $past(s.cmpEn[k]) && ($past(counter) == $past(s.value[k]));
			endproperty
			a_match_cause: assert property (p_match_cause) else $error("match without cause");
		end
	endgenerate

endmodule : ccv_value_regs

// ==== ccv_value_regs_tb.sv ====
/*
 * Self-checking bench for the capture/compare value registers.
 * Assumes ccv_pkg, the interface and the design modules are compiled first.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ccv_value_regs_tb;
	import ccv_pkg::*;
	logic                              clock;
	logic                              rst;
	logic [7:0]                        sfrAddr;
	logic                              sfrWrite;
	logic                              sfrRead;
	logic [BYTE_W-1:0]                 sfrWrData;
	logic [BYTE_W-1:0]                 sfrRdData;
	logic [MOD_COUNT-1:0]              modeWrite;
	logic [BYTE_W-1:0]                 modeWrData;
	logic [VALUE_W-1:0]                counter;
	logic [MOD_COUNT-1:0]              compareEnable;
	logic [MOD_COUNT-1:0][VALUE_W-1:0] moduleValue;
	logic [MOD_COUNT-1:0]              compareMatch;
	logic [7:0]                        lo;
	logic [7:0]                        hi;
	int                                fails = 0;
	int                                compares = 0;

	ccv_value_regs u_dut (
		.clock         (clock),
		.rst           (rst),
		.sfrAddr       (sfrAddr),
		.sfrWrite      (sfrWrite),
		.sfrRead       (sfrRead),
		.sfrWrData     (sfrWrData),
		.sfrRdData     (sfrRdData),
		.modeWrite     (modeWrite),
		.modeWrData    (modeWrData),
		.counter       (counter),
		.compareEnable (compareEnable),
		.moduleValue   (moduleValue),
		.compareMatch  (compareMatch)
	);

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Strobes stay up between calls so back-to-back cycles never double-assign
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrRead   = 1'b0;
		sfrAddr   = a;
		sfrWrData = d;
		sfrWrite  = 1'b1;
		@(negedge clock);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfrWrite = 1'b0;
		sfrAddr  = a;
		sfrRead  = 1'b1;
		@(negedge clock);
		`CHK(sfrRdData, e)
	endtask : rd

	task automatic mode(input logic [MOD_COUNT-1:0] m, input logic [7:0] d);
		modeWrite  = m;
		modeWrData = d;
		@(negedge clock);
	endtask : mode

	task automatic idle(input int n);
		sfrWrite  = 1'b0;
		sfrRead   = 1'b0;
		modeWrite = '0;
		repeat (n) @(negedge clock);
	endtask : idle

	task automatic give_verdict;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		repeat (2000) @(posedge clock);
		fails++;
		give_verdict();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst = 1'b1; sfrAddr = 8'h00; sfrWrite = 1'b0; sfrRead = 1'b0; sfrWrData = 8'h00;
		modeWrite = '0; modeWrData = 8'h00; counter = 16'h0000;
		repeat (12) @(negedge clock);
		rst = 1'b0;
		for (int i = 0; i < MOD_COUNT; i++) begin
			rd(ADDR_LOW[i], BYTE_RESET);
			rd(ADDR_HIGH[i], BYTE_RESET);
		end
		idle(1);
		`CHK(sfrRdData, IDLE_READ)
		`CHK(compareEnable, 5'h00)
		$display("test reset done");
		for (int i = 0; i < MOD_COUNT; i++) begin
			lo = 8'(8'h30 + i);
			hi = 8'(8'hc0 + i);
			wr(ADDR_HIGH[i], 8'h11);
			`CHK(compareEnable[i], 1'b1)
			wr(ADDR_LOW[i], lo);
			`CHK(compareEnable[i], 1'b0)
			`CHK(moduleValue[i], {8'h11, lo})
			wr(ADDR_HIGH[i], hi);
			`CHK(compareEnable[i], 1'b1)
			`CHK(moduleValue[i], {hi, lo})
		end
		for (int i = 0; i < MOD_COUNT; i++) begin
			rd(ADDR_LOW[i], 8'(8'h30 + i));
			rd(ADDR_HIGH[i], 8'(8'hc0 + i));
		end
		$display("test value bytes done");
		// Unmapped place next to the value bytes
		wr(8'hfa, 8'hff);
		rd(8'hfa, 8'h00);
		idle(1);
		for (int i = 0; i < MOD_COUNT; i++) begin
			`CHK(moduleValue[i], {8'(8'hc0 + i), 8'(8'h30 + i)})
		end
		`CHK(compareEnable, 5'h1f)
		$display("test unmapped done");
		mode(5'b00010, 8'h00);
		`CHK(compareEnable, 5'b11101)
		mode(5'b00100, 8'hbf);
		`CHK(compareEnable, 5'b11001)
		mode(5'b00010, 8'h40);
		`CHK(compareEnable, 5'b11011)
		$display("test mode link done");
		counter = 16'hc333;
		idle(1);
		`CHK(compareMatch, 5'b01000)
		wr(ADDR_LOW[3], 8'h33);
		idle(2);
		`CHK(compareMatch[3], 1'b0)
		wr(ADDR_HIGH[3], 8'hc3);
		idle(1);
		`CHK(compareMatch[3], 1'b1)
		$display("test compare done");
		// Second reset in mid-run must clear everything again
		rst = 1'b1;
		idle(1);
		rst = 1'b0;
		`CHK(moduleValue, '0)
		`CHK(compareMatch, 5'h00)
		`CHK(compareEnable, 5'h00)
		rd(ADDR_HIGH[3], BYTE_RESET);
		$display("test second reset done");
		give_verdict();
	end
endmodule : ccv_value_regs_tb
